// *** rtl/fmon_pkg.sv ***
package fmon_pkg;

   // Register indices on the plain register port.
   localparam logic [7:0] FMON_OFS_STATUS   = 8'h01;
   localparam logic [7:0] FMON_OFS_REFCTL   = 8'h05;
   localparam logic [7:0] FMON_OFS_EXC1     = 8'h06;
   localparam logic [7:0] FMON_OFS_SYSCTL   = 8'h09;
   localparam logic [7:0] FMON_OFS_PINDATA  = 8'h10;
   localparam logic [7:0] FMON_OFS_PINFUNC  = 8'h11;

   // Status byte bit positions.
   localparam int FMON_ST_POR    = 7;
   localparam int FMON_ST_READY  = 6;
   localparam int FMON_ST_PHI    = 5;
   localparam int FMON_ST_PLO    = 4;
   localparam int FMON_ST_NHI    = 3;
   localparam int FMON_ST_NLO    = 2;
   localparam int FMON_ST_REF3   = 1;
   localparam int FMON_ST_REF0   = 0;

   // Control field positions.
   localparam int FMON_SYS_MON_LSB  = 5;
   localparam int FMON_SYS_SEND     = 0;
   localparam int FMON_EXC_SWITCH   = 7;
   localparam int FMON_EXC_RAIL_EN  = 3;
   localparam int FMON_REF_EN_LSB   = 6;

   // Reset values.
   localparam logic [7:0] FMON_RST_SYSCTL  = 8'h10;
   localparam logic [7:0] FMON_RST_EXC1    = 8'h00;
   localparam logic [7:0] FMON_RST_REFCTL  = 8'h00;
   localparam logic [7:0] FMON_RST_PINDATA = 8'h00;
   localparam logic [7:0] FMON_RST_PINFUNC = 8'h00;

   // Start-up time before the ready flag rises.
   localparam int FMON_STARTUP_NS  = 2200;
   localparam int FMON_CLK_NS      = 50;
   localparam int FMON_STARTUP_CYC = (FMON_STARTUP_NS + FMON_CLK_NS - 1) / FMON_CLK_NS;

   // Monitor select codes.
   typedef enum logic [2:0] {
      FMON_MON_NONE  = 3'h0,
      FMON_MON_MID   = 3'h1,
      FMON_MON_TEMP  = 3'h2,
      FMON_MON_AVDD  = 3'h3,
      FMON_MON_DVDD  = 3'h4,
      FMON_MON_BO02  = 3'h5,
      FMON_MON_BO1   = 3'h6,
      FMON_MON_BO10  = 3'h7
   } fmon_mon_t;

   // Analog routing controls handed to the front end.
   typedef struct packed {
      logic       inputs_off;
      logic       temp_sel;
      logic       avdd_sel;
      logic       dvdd_sel;
      logic       gain_one;
      logic [2:0] open_sensor_current_source;
   } fmon_route_t;

   // Raw fault comparators from the analog side.
   typedef struct packed {
      logic pos_hi;
      logic pos_lo;
      logic neg_hi;
      logic neg_lo;
      logic ref_low;
      logic ref_third;
   } fmon_fault_t;

endpackage : fmon_pkg

// *** rtl/fmon_route.sv ***
`timescale 1ns/10ps
module fmon_route
   import fmon_pkg::*;
(
   input  wire logic [2:0]  monitor_select_field,
   input  wire logic [2:0]  gain_field,
   output fmon_route_t      route,
   output logic [2:0]       eff_gain
);

   fmon_mon_t sel;

   // Decode of the monitor-select field; every code is legal so no default.
   always_comb begin
      sel   = fmon_mon_t'(monitor_select_field);
      route = '0;
      unique case (sel)
         FMON_MON_NONE: route = '0;
         FMON_MON_MID:  route.inputs_off = 1'b1;
         FMON_MON_TEMP: begin
            route.inputs_off = 1'b1;
            route.temp_sel   = 1'b1;
         end
         FMON_MON_AVDD: begin
            route.inputs_off = 1'b1;
            route.avdd_sel   = 1'b1;
            route.gain_one   = 1'b1;
         end
         FMON_MON_DVDD: begin
            route.inputs_off = 1'b1;
            route.dvdd_sel   = 1'b1;
            route.gain_one   = 1'b1;
         end
         // One-hot levels 0.2 uA, 1 uA, 10 uA; inputs stay connected so the
         // source feeds the positive input and the sink drains the negative one.
         FMON_MON_BO02: route.open_sensor_current_source = 3'h1;
         FMON_MON_BO1:  route.open_sensor_current_source = 3'h2;
         FMON_MON_BO10: route.open_sensor_current_source = 3'h4;
      endcase
   end

   // A supply measurement overrides the programmed gain code with unity.
   assign eff_gain = route.gain_one ? 3'h0 : gain_field;

endmodule : fmon_route

// *** rtl/fmon_pins.sv ***
`timescale 1ns/10ps
module fmon_pins #(
   parameter int NPIN = 4
) (
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic [NPIN-1:0] func_bits,
   input  wire logic [NPIN-1:0] dir_bits,
   input  wire logic [NPIN-1:0] out_bits,
   input  wire logic [NPIN-1:0] pin_i,
   output logic      [NPIN-1:0] pin_o,
   output logic      [NPIN-1:0] pin_oe,
   output logic      [NPIN-1:0] level_bits
);

   logic [NPIN-1:0] sync1;
   logic [NPIN-1:0] sync2;

   // Two-stage synchroniser for the asynchronous pin levels.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pin_i;
         sync2 <= sync1;
      end
   end

   // Per pin: a direction bit of 1 makes it an input, else it drives its data bit when its function bit is set.
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            pin_o[i]  <= 1'b0;
            pin_oe[i] <= 1'b0;
         end else begin
            pin_o[i]  <= out_bits[i];
            pin_oe[i] <= func_bits[i] & ~dir_bits[i];
         end
      end
      assign level_bits[i] = dir_bits[i] ? sync2[i] : out_bits[i];
   end

endmodule : fmon_pins

// *** rtl/fmon_top.sv ***
// Behaviour
// - Select code 011 routes scaled analog supply, 100 scaled logic supply.
// - Supply monitor disconnects inputs and forces amplifier gain to one.
// - Codes 101, 110, 111 enable 0.2, 1 and 10 uA burn-out sources.
// - Burn-out sources feed the positive input and sink the negative input.
// - Status readable at 01h; prepended to results when append bit is set.
// - Rail and reference faults latch per cycle, flags update at conversion end.
// - Power-up flag bit 7 sets on power-on, clears only by writing zero.
// - Bit 6 shows start-up finished and configuration accepted.
// - Bits 5 to 2: pos high, pos low, neg high, neg low.
// - Rail monitors work only when enabled, also with amplifier bypassed.
// - Reference detect enable sets bit 0 below 0.3 V, bit 1 below third.
// - Reference faults latch each cycle, flags refresh on strobe falling edge.
// - Function bits at 11h choose per pin whether it is general purpose.
// - Register 10h: upper nibble direction, lower nibble data.
// - Input pins read their level; output pins drive written data.
// - Switch closes while its bit at 06h is one, opens at zero.
// - A sleep command opens the switch regardless of earlier setting.
// - After reset the switch is open.
// - Select code 010 routes the temperature sensor and disconnects inputs.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module fmon_top
   import fmon_pkg::*;
#(
   parameter int NPIN = 4
) (
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [7:0]      reg_rdata,
   input  wire logic            por_event,
   input  wire logic            conv_end,
   input  wire fmon_fault_t     fault_raw,
   input  wire logic            sleep_command,
   input  wire logic [2:0]      gain_field,
   output fmon_route_t          route,
   output logic      [2:0]      eff_gain,
   output logic                 rail_mon_on,
   output logic      [1:0]      reference_detect_enable,
   output logic                 append_fault_byte_bit,
   output logic                 conversion_done_strobe_n,
   output logic                 switch_closed,
   input  wire logic [NPIN-1:0] pin_i,
   output logic      [NPIN-1:0] pin_o,
   output logic      [NPIN-1:0] pin_oe
);

   localparam int SUW = $clog2(FMON_STARTUP_CYC + 1);

   logic [7:0]      sysctl;
   logic [7:0]      exc1;
   logic [7:0]      refctl;
   logic [7:0]      pindata;
   logic [7:0]      pinfunc;
   logic [7:0]      status;
   logic            por_s1;
   logic            por_s2;
   logic            por_d;
   logic            power_up_event_flag;
   logic            ready;
   logic [SUW-1:0]  su_cnt;
   logic [3:0]      rail_acc;
   logic [1:0]      ref_acc;
   logic [3:0]      rail_flags;
   logic [1:0]      ref_flags;
   logic [NPIN-1:0] level_bits;
   logic            wr_ok;
   logic            por_rise;
   logic [7:0]      next_rdata;

   // Writes are refused until start-up completes, matching the ready flag.
   assign wr_ok = reg_wr & ready;

   // Configuration registers written by software.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sysctl  <= FMON_RST_SYSCTL;
         exc1    <= FMON_RST_EXC1;
         refctl  <= FMON_RST_REFCTL;
         pindata <= FMON_RST_PINDATA;
         pinfunc <= FMON_RST_PINFUNC;
      end else begin
         if (wr_ok && reg_addr == FMON_OFS_SYSCTL) begin
            sysctl <= reg_wdata;
         end
         if (wr_ok && reg_addr == FMON_OFS_REFCTL) begin
            refctl <= reg_wdata;
         end
         if (wr_ok && reg_addr == FMON_OFS_PINDATA) begin
            pindata <= reg_wdata;
         end
         if (wr_ok && reg_addr == FMON_OFS_PINFUNC) begin
            pinfunc <= reg_wdata;
         end
         // Sleep wins over a simultaneous write so the switch cannot reclose.
         if (sleep_command) begin
            exc1[FMON_EXC_SWITCH] <= 1'b0;
         end else if (wr_ok && reg_addr == FMON_OFS_EXC1) begin
            exc1 <= reg_wdata;
         end
      end
   end

   // The power-on event arrives from analog supervisors, so it is synchronised.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         por_s1 <= 1'b0;
         por_s2 <= 1'b0;
         por_d  <= 1'b0;
      end else begin
         por_s1 <= por_event;
         por_s2 <= por_s1;
         por_d  <= por_s2;
      end
   end

   assign por_rise = por_s2 & ~por_d;

   // Power-up flag: set by reset or a power-on event, set wins over a clear.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         power_up_event_flag <= 1'b1;
      end else if (por_rise) begin
         power_up_event_flag <= 1'b1;
      end else if (wr_ok && reg_addr == FMON_OFS_STATUS && !reg_wdata[FMON_ST_POR]) begin
         power_up_event_flag <= 1'b0;
      end
   end

   // Start-up timer; register writes are refused until it expires, reads still work.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         su_cnt <= '0;
         ready  <= 1'b0;
      end else if (!ready) begin
         if (su_cnt == SUW'(FMON_STARTUP_CYC - 1)) begin
            ready <= 1'b1;
         end
         su_cnt <= su_cnt + 1'b1;
      end
   end

   // Faults accumulate during a cycle and are moved to flags at conversion end.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rail_acc   <= '0;
         ref_acc    <= '0;
         rail_flags <= '0;
         ref_flags  <= '0;
      end else if (conv_end) begin
         rail_flags <= rail_acc | ({4{rail_mon_on}} & {fault_raw.pos_hi, fault_raw.pos_lo,
                        fault_raw.neg_hi, fault_raw.neg_lo});
         ref_flags  <= ref_acc | ({fault_raw.ref_third, fault_raw.ref_low}
                        & reference_detect_enable);
         rail_acc   <= '0;
         ref_acc    <= '0;
      end else begin
         if (rail_mon_on) begin
            rail_acc <= rail_acc | {fault_raw.pos_hi, fault_raw.pos_lo,
                        fault_raw.neg_hi, fault_raw.neg_lo};
         end
         ref_acc <= ref_acc | ({fault_raw.ref_third, fault_raw.ref_low}
                     & reference_detect_enable);
      end
   end

   // Data-ready falls with the flag update and rises again on the next cycle.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         conversion_done_strobe_n <= 1'b1;
      end else begin
         conversion_done_strobe_n <= ~conv_end;
      end
   end

   assign status = {power_up_event_flag, ready, rail_flags, ref_flags};

   assign append_fault_byte_bit   = sysctl[FMON_SYS_SEND];
   assign rail_mon_on             = exc1[FMON_EXC_RAIL_EN];
   assign reference_detect_enable = refctl[FMON_REF_EN_LSB +: 2];

   // Switch output is registered so it follows the bit one cycle later.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         switch_closed <= 1'b0;
      end else begin
         switch_closed <= exc1[FMON_EXC_SWITCH] & ~sleep_command;
      end
   end

   // Read mux; unmapped addresses read zero.
   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_addr)
         FMON_OFS_STATUS:  next_rdata = status;
         FMON_OFS_REFCTL:  next_rdata = refctl;
         FMON_OFS_EXC1:    next_rdata = exc1;
         FMON_OFS_SYSCTL:  next_rdata = sysctl;
         FMON_OFS_PINDATA: next_rdata = {pindata[7:4], level_bits};
         FMON_OFS_PINFUNC: next_rdata = pinfunc;
         default:          next_rdata = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   fmon_route u_route (
      .monitor_select_field (sysctl[FMON_SYS_MON_LSB +: 3]),
      .gain_field           (gain_field),
      .route                (route),
      .eff_gain             (eff_gain)
   );

   fmon_pins #(.NPIN(NPIN)) u_pins (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .func_bits  (pinfunc[NPIN-1:0]),
      .dir_bits   (pindata[4 +: NPIN]),
      .out_bits   (pindata[NPIN-1:0]),
      .pin_i      (pin_i),
      .pin_o      (pin_o),
      .pin_oe     (pin_oe),
      .level_bits (level_bits)
   );

   // Supply selection must force unity gain and disconnect inputs.
   supply_gain_a: assert property (@(posedge clk_sys) disable iff (rst)
      (route.avdd_sel || route.dvdd_sel) |-> (eff_gain == 3'h0 && route.inputs_off))
      else $error("supply monitor without unity gain");

   // Analog supply code routes the analog monitor only.
   avdd_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      (sysctl[7:5] == 3'h3) |-> (route.avdd_sel && !route.dvdd_sel))
      else $error("analog supply not routed");

   // Burn-out code 111 selects the largest source.
   burnout_max_a: assert property (@(posedge clk_sys) disable iff (rst)
      (sysctl[7:5] == 3'h7) |-> (route.open_sensor_current_source == 3'h4))
      else $error("burn-out level wrong");

   // Rail flags hold between conversion ends.
   rail_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(conv_end) |-> $stable(status[5:2]))
      else $error("rail flag moved outside conversion end");

   // Reference flags refresh together with the falling strobe.
   ref_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
      !$stable(status[1:0]) |-> $fell(conversion_done_strobe_n))
      else $error("reference flag moved without strobe");

   // Power-up flag never clears without a write to the status register.
   por_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(power_up_event_flag) |-> $past(reg_wr && reg_addr == FMON_OFS_STATUS))
      else $error("power-up flag cleared without write");

   // Sleep opens the switch on the next edge.
   sleep_open_a: assert property (@(posedge clk_sys) disable iff (rst)
      sleep_command |=> !switch_closed [*2])
      else $error("switch closed after sleep");

   // An output pin drives its data bit one cycle after configuration.
   pin_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
      (pinfunc[0] && !pindata[4]) ##1 $stable(pindata[0]) |-> pin_oe[0] && pin_o[0] == pindata[0])
      else $error("output pin not driven");

   // Ready rises only after the full start-up count.
   ready_time_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(ready) |-> su_cnt == SUW'(FMON_STARTUP_CYC))
      else $error("ready timing wrong");

   // Logic supply code routes the logic monitor only.
   dvdd_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      (sysctl[7:5] == 3'h4) |-> (route.dvdd_sel && !route.avdd_sel && route.inputs_off))
      else $error("logic supply not routed");

   // Temperature code disconnects the inputs and routes the sensor.
   temp_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      (sysctl[7:5] == 3'h2) |-> (route.temp_sel && route.inputs_off))
      else $error("temperature sensor not routed");

   // Code zero leaves every routing control idle.
   idle_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      (sysctl[7:5] == 3'h0) |-> (route == '0))
      else $error("routing active with no monitor");

   // The smallest source keeps the inputs connected, since it probes them.
   burnout_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      (sysctl[7:5] == 3'h5) |-> (route.open_sensor_current_source == 3'h1 && !route.inputs_off))
      else $error("burn-out low level wrong");

   // Code 110 selects the middle source level.
   burnout_mid_a: assert property (@(posedge clk_sys) disable iff (rst)
      (sysctl[7:5] == 3'h6) |-> (route.open_sensor_current_source == 3'h2))
      else $error("burn-out middle level wrong");

   // Every conversion end drops the done strobe in the next cycle.
   strobe_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      conv_end |=> !conversion_done_strobe_n)
      else $error("done strobe missing");

   // A set switch bit closes the switch unless a sleep command is pending.
   switch_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
      (exc1[FMON_EXC_SWITCH] && !sleep_command) |=> switch_closed)
      else $error("switch not closed");

   // A cleared switch bit opens the switch.
   switch_open_a: assert property (@(posedge clk_sys) disable iff (rst)
      !exc1[FMON_EXC_SWITCH] |=> !switch_closed)
      else $error("switch not opened");

   // A status write cannot move the fault flags.
   status_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      (reg_wr && reg_addr == FMON_OFS_STATUS && !conv_end) |=> $stable(status[5:0]))
      else $error("fault flags changed by a write");

   // A write before start-up ends is dropped.
   early_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      (reg_wr && !ready) |=> $stable(sysctl))
      else $error("write taken before ready");

   // Read data return to zero when no read was strobed.
   rdata_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      !reg_rd |=> (reg_rdata == 8'h00))
      else $error("read data without strobe");

   // A synchronised power-on edge sets the power-up flag.
   por_set_a: assert property (@(posedge clk_sys) disable iff (rst)
      por_rise |=> power_up_event_flag)
      else $error("power-up flag not set");

   // A pin not used as general purpose never drives.
   pin_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      !pinfunc[0] |=> !pin_oe[0])
      else $error("unused pin driven");

endmodule : fmon_top

// *** test/fmon_host.sv ***
`timescale 1ns/10ps
// Host processor model: issues one-cycle register strobes on the plain register port.
module fmon_host (
   input  wire logic       clk_sys,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   // The bus is idle from time zero so nothing is taken during reset.
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // One write: strobe, address and data change just after an edge and drop after the next.
   // Released lines are inverted so a stale value can never pass for a held one.
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      reg_addr  <= addr;
      reg_wdata <= data;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_addr  <= ~addr;
      reg_wdata <= ~data;
      #1;
   endtask : wr

   // One read: the data stand only in the cycle after the strobe and are taken there.
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk_sys);
      reg_addr <= addr;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~addr;
      #1;
      data = reg_rdata;
   endtask : rd

   // Monitor selection; one write of the select code and the append bit.
   task automatic set_monitor(input logic [2:0] code, input logic append);
      wr(8'h09, {code, 4'h0, append});
   endtask : set_monitor

   // The power-up flag is acknowledged by writing zero into the status byte.
   task automatic clear_power_flag;
      wr(8'h01, 8'h00);
   endtask : clear_power_flag
endmodule : fmon_host

// *** test/fmon_top_tb.sv ***
`timescale 1ns/10ps
module fmon_top_tb;
   import fmon_pkg::*;

   logic        clk_sys;
   logic        rst;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        por_event;
   logic        conv_end;
   fmon_fault_t fault_raw;
   logic        sleep_command;
   logic [2:0]  gain_field;
   fmon_route_t route;
   logic [2:0]  eff_gain;
   logic        rail_mon_on;
   logic [1:0]  ref_en;
   logic        append_bit;
   logic        strobe_n;
   logic        switch_closed;
   logic [3:0]  pin_i;
   logic [3:0]  pin_o;
   logic [3:0]  pin_oe;
   logic [7:0]  v;
   int          err_total;
   int          tests_run;

   // Free-running 20 MHz clock.
   always #25 clk_sys = ~clk_sys;

   fmon_host h (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   fmon_top #(.NPIN(4)) dut (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_event(por_event),
      .conv_end(conv_end), .fault_raw(fault_raw), .sleep_command(sleep_command),
      .gain_field(gain_field), .route(route), .eff_gain(eff_gain),
      .rail_mon_on(rail_mon_on), .reference_detect_enable(ref_en),
      .append_fault_byte_bit(append_bit), .conversion_done_strobe_n(strobe_n),
      .switch_closed(switch_closed), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));

   // Compare a seen value with the expected one and count both outcomes.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Report the counts and end the run.
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // One conversion end; the done strobe must be low for exactly the following cycle.
   task automatic conv_pulse;
      @(posedge clk_sys);
      conv_end <= 1'b1;
      @(posedge clk_sys);
      conv_end <= 1'b0;
      #1 chk({7'h00, strobe_n}, 8'h00);
      @(posedge clk_sys);
      #1 chk({7'h00, strobe_n}, 8'h01);
   endtask : conv_pulse

   // Reset values, early writes refused until ready, then the ready flag itself.
   task automatic t_reset;
      h.rd(FMON_OFS_STATUS, v);
      chk(v, 8'h80);
      chk({7'h00, switch_closed}, 8'h00);
      chk({4'h0, pin_oe}, 8'h00);
      h.wr(FMON_OFS_SYSCTL, 8'hE0);
      for (int n = 0; n < 60 && v[FMON_ST_READY] !== 1'b1; n++) h.rd(FMON_OFS_STATUS, v);
      if (v[FMON_ST_READY] !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      chk(v, 8'hC0);
      chk(route, 8'h00);
      h.rd(FMON_OFS_SYSCTL, v);
      chk(v, 8'h10);
      h.rd(8'h3E, v);
      chk(v, 8'h00);
   endtask : t_reset

   // Every monitor code, with a non-unity programmed gain to expose the gain override.
   task automatic t_monitor;
      fmon_route_t e;
      logic [2:0]  c;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         h.set_monitor(c, 1'b0);
         e.inputs_off = (c >= 3'h1) && (c <= 3'h4);
         e.temp_sel   = (c == 3'h2);
         e.avdd_sel   = (c == 3'h3);
         e.dvdd_sel   = (c == 3'h4);
         e.gain_one   = (c == 3'h3) || (c == 3'h4);
         e.open_sensor_current_source = (c == 3'h5) ? 3'h1 : (c == 3'h6) ? 3'h2 :
                                        (c == 3'h7) ? 3'h4 : 3'h0;
         chk(route, e);
         chk({5'h00, eff_gain}, e.gain_one ? 8'h00 : {5'h00, gain_field});
      end
      h.set_monitor(3'h0, 1'b1);
      chk({7'h00, append_bit}, 8'h01);
      h.rd(FMON_OFS_SYSCTL, v);
      chk(v, 8'h01);
      h.set_monitor(3'h0, 1'b0);
      chk({7'h00, append_bit}, 8'h00);
   endtask : t_monitor

   // Each fault latches only at conversion end, lands on its own bit, and clears after.
   task automatic t_faults;
      logic [7:0] e;
      h.clear_power_flag();
      h.rd(FMON_OFS_STATUS, v);
      chk(v, 8'h40);
      h.wr(FMON_OFS_STATUS, 8'h3F);
      h.rd(FMON_OFS_STATUS, v);
      chk(v, 8'h40);
      h.wr(FMON_OFS_EXC1, 8'h08);
      h.wr(FMON_OFS_REFCTL, 8'hC0);
      chk({4'h0, ref_en, rail_mon_on, 1'b0}, 8'h0E);
      for (int i = 0; i < 6; i++) begin
         e = 8'h40;
         e[(i > 1) ? i : (i == 1) ? FMON_ST_REF0 : FMON_ST_REF3] = 1'b1;
         @(posedge clk_sys);
         fault_raw <= fmon_fault_t'(6'h01 << i);
         @(posedge clk_sys);
         fault_raw <= '0;
         h.rd(FMON_OFS_STATUS, v);
         chk(v, 8'h40);
         conv_pulse();
         h.rd(FMON_OFS_STATUS, v);
         chk(v, e);
         conv_pulse();
         h.rd(FMON_OFS_STATUS, v);
         chk(v, 8'h40);
      end
      h.wr(FMON_OFS_EXC1, 8'h00);
      h.wr(FMON_OFS_REFCTL, 8'h40);
      @(posedge clk_sys);
      fault_raw <= '1;
      conv_pulse();
      @(posedge clk_sys);
      fault_raw <= '0;
      h.rd(FMON_OFS_STATUS, v);
      chk(v, 8'h41);
      @(posedge clk_sys);
      por_event <= 1'b1;
      repeat (6) @(posedge clk_sys);
      h.rd(FMON_OFS_STATUS, v);
      chk(v, 8'hC1);
      @(posedge clk_sys);
      por_event <= 1'b0;
      h.clear_power_flag();
      h.rd(FMON_OFS_STATUS, v);
      chk(v, 8'h41);
   endtask : t_faults

   // Two outputs and two inputs, then a function change that stops output pin 1 driving.
   task automatic t_pins;
      h.wr(FMON_OFS_PINFUNC, 8'h0F);
      h.wr(FMON_OFS_PINDATA, 8'hC3);
      repeat (3) @(posedge clk_sys);
      #1 chk({4'h0, pin_oe}, 8'h03);
      chk({6'h00, pin_o[1:0]}, 8'h03);
      h.rd(FMON_OFS_PINDATA, v);
      chk(v, 8'hCB);
      @(posedge clk_sys);
      pin_i <= 4'h5;
      repeat (4) @(posedge clk_sys);
      h.rd(FMON_OFS_PINDATA, v);
      chk(v, 8'hC7);
      h.wr(FMON_OFS_PINDATA, 8'hC0);
      h.wr(FMON_OFS_PINFUNC, 8'h01);
      repeat (3) @(posedge clk_sys);
      #1 chk({4'h0, pin_oe}, 8'h01);
      chk({7'h00, pin_o[0]}, 8'h00);
      h.rd(FMON_OFS_PINFUNC, v);
      chk(v, 8'h01);
   endtask : t_pins

   // Switch closes on its bit, opens on a sleep command, and again when cleared.
   task automatic t_switch;
      h.wr(FMON_OFS_EXC1, 8'h80);
      @(posedge clk_sys);
      #1 chk({7'h00, switch_closed}, 8'h01);
      @(posedge clk_sys);
      sleep_command <= 1'b1;
      @(posedge clk_sys);
      sleep_command <= 1'b0;
      @(posedge clk_sys);
      #1 chk({7'h00, switch_closed}, 8'h00);
      h.rd(FMON_OFS_EXC1, v);
      chk(v, 8'h00);
      h.wr(FMON_OFS_EXC1, 8'h80);
      h.wr(FMON_OFS_EXC1, 8'h00);
      @(posedge clk_sys);
      #1 chk({7'h00, switch_closed}, 8'h00);
   endtask : t_switch

   // Main sequence: every input has a value at time zero, reset is held two cycles.
   initial begin
      clk_sys       = 1'b0;
      rst           = 1'b1;
      por_event     = 1'b0;
      conv_end      = 1'b0;
      fault_raw     = '0;
      sleep_command = 1'b0;
      gain_field    = 3'h5;
      pin_i         = 4'hA;
      err_total     = 0;
      tests_run     = 0;
      v             = 8'h00;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_monitor();
      t_faults();
      t_pins();
      t_switch();
      print_verdict();
   end
endmodule : fmon_top_tb
